// ### common/fr_pkg.sv
// Constants, register map and state codes of the RF packet framer.
// Assumes a single 10 MHz clock domain and an 8-bit register port.
package fr_pkg;
  // Register offsets
  localparam logic [6:0] REG_CTRL_A = 7'h18;
  localparam logic [6:0] REG_LEAD = 7'h19;
  localparam logic [6:0] REG_CTRL_B = 7'h27;
  localparam logic [6:0] REG_STATUS = 7'h28;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] LEAD_RST = 8'h55;
  // Field positions of frame_control_a
  localparam int A_ENGINE = 0;
  localparam int A_PREAMBLE = 1;
  localparam int A_FIXLEN = 2;
  localparam int A_ADDR = 3;
  localparam int A_CRC = 4;
  localparam int A_MULTI = 5;
  localparam int A_WHITE = 6;
  localparam int A_LSB = 7;
  // Field positions of frame_control_b
  localparam int B_UNPACK = 0;
  localparam int B_BIPHASE = 1;
  localparam int B_INVERT = 2;
  localparam int B_SYNC_LEN = 3;
  localparam int B_LEN_POS = 5;
  // Field positions of the status register
  localparam int ST_DONE = 0;
  localparam int ST_RESULT = 1;
  // Checksum and whitening
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  // Receive result codes
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_CRC_ERR = 3'h1;
  // Modulation source selector
  localparam logic [3:0] DM_LAST_FRAMED = 4'h2;
  localparam logic [3:0] DM_FIXED1 = 4'h4;
  localparam logic [3:0] DM_GPIO0 = 4'h5;
  // Sequencer states, shared by both directions
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_SYNC = 3'b010,
    ST_HUNT = 3'b011,
    ST_HEAD = 3'b100,
    ST_BODY = 3'b101,
    ST_CRC = 3'b110
  } fr_st_e;
endpackage

// ### common/fr_lane_if.sv
// Signals between a framer direction and its whitening/checksum lane.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fr_lane_if;
  logic init;
  logic step;
  logic crc_en;
  logic bit_plain;
  logic mask_bit;
  logic [15:0] crc;
  modport owner (output init, output step, output crc_en, output bit_plain,
                 input mask_bit, input crc);
  modport lane (input init, input step, input crc_en, input bit_plain,
                output mask_bit, output crc);
endinterface
`default_nettype wire

// ### design/fr_lane.sv
// PN9 whitening sequence and CRC16 over plain data bits.
// Assumes init and step are never needed in the same cycle; init wins.
`timescale 1ns/1ps
`default_nettype none
module fr_lane (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Lane port
  fr_lane_if.lane lp
);
  logic [8:0] pn9_r;
  logic [15:0] crc_r;

  assign lp.mask_bit = pn9_r[0];
  assign lp.crc = crc_r;

  // x^9 + x^5 + 1, seeded with all ones per frame
  always_ff @(posedge clk_in) begin
    if (reset_in || lp.init) begin
      pn9_r <= fr_pkg::PN9_SEED;
    end else if (lp.step) begin
      pn9_r <= {pn9_r[0] ^ pn9_r[5], pn9_r[8:1]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || lp.init) begin
      crc_r <= fr_pkg::CRC_SEED;
    end else if (lp.step && lp.crc_en) begin
      crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ lp.bit_plain) ? fr_pkg::CRC_POLY : 16'h0000);
    end
  end
endmodule
`default_nettype wire

// ### design/fr_framer.sv
// RF packet framer: builds transmit frames and parses receive frames.
// Assumes synchronous inputs, FIFO on the byte side, chip stream on the radio side.
`timescale 1ns/1ps
`default_nettype none
module fr_framer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Frame settings
  input wire logic [1:0] lead_repeat_in,
  input wire logic [31:0] sync_word_in,
  input wire logic [7:0] fixed_len_in,
  input wire logic [7:0] len_adjust_in,
  input wire logic [7:0] address_in,
  input wire logic [3:0] direct_mod_in,
  input wire logic [3:0] gpio_in,
  // Radio mode requests
  input wire logic tx_start_in,
  input wire logic rx_start_in,
  // Transmit FIFO side
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_byte_valid_in,
  output logic tx_byte_ready_out,
  // Transmit chip stream
  output logic tx_chip_out,
  output logic tx_chip_valid_out,
  input wire logic tx_chip_ready_in,
  // Receive chip stream
  input wire logic rx_chip_in,
  input wire logic rx_chip_valid_in,
  // Receive FIFO side
  output logic [7:0] rx_byte_out,
  output logic rx_byte_valid_out,
  // Status
  output logic tx_busy_out,
  output logic rx_done_out,
  output logic [2:0] rx_result_code_out
);
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] lead_r;
  logic [7:0] rdata_r;
  logic rx_done_r;
  logic [2:0] rx_result_r;
  logic eng_en, rx_en, pre_en, fix_en, addr_en, crc_en, multi_en, white_en, lsb_en;
  logic bip_en, inv_en;
  logic [1:0] sync_sel;
  logic [1:0] len_pos;
  logic [1:0] sync_last;
  logic [31:0] sync_mask;
  logic [31:0] sync_al;
  fr_pkg::fr_st_e fs_st;
  logic [8:0] fs_cnt;

  fr_lane_if tx_lane ();
  fr_lane_if rx_lane ();

  assign eng_en = ctrl_a_r[fr_pkg::A_ENGINE];
  assign rx_en = eng_en && ctrl_b_r[fr_pkg::B_UNPACK];
  assign pre_en = ctrl_a_r[fr_pkg::A_PREAMBLE];
  assign fix_en = ctrl_a_r[fr_pkg::A_FIXLEN];
  assign addr_en = ctrl_a_r[fr_pkg::A_ADDR];
  assign crc_en = ctrl_a_r[fr_pkg::A_CRC];
  assign multi_en = ctrl_a_r[fr_pkg::A_MULTI];
  assign white_en = ctrl_a_r[fr_pkg::A_WHITE];
  assign lsb_en = ctrl_a_r[fr_pkg::A_LSB];
  assign bip_en = ctrl_b_r[fr_pkg::B_BIPHASE];
  assign inv_en = ctrl_b_r[fr_pkg::B_INVERT];
  assign sync_sel = ctrl_b_r[fr_pkg::B_SYNC_LEN +: 2];
  assign len_pos = ctrl_b_r[fr_pkg::B_LEN_POS +: 2];

  // Sync length: 2 or 3 selects 24 or 32 bits, else 16
  assign sync_last = (sync_sel == 2'h3) ? 2'h3 : ((sync_sel == 2'h2) ? 2'h2 : 2'h1);
  assign sync_mask = (sync_sel == 2'h3) ? 32'hffffffff :
                     ((sync_sel == 2'h2) ? 32'hffffff00 : 32'hffff0000);
  assign sync_al = (sync_sel == 2'h3) ? sync_word_in :
                   ((sync_sel == 2'h2) ? {sync_word_in[23:0], 8'h00} : {sync_word_in[15:0], 16'h0000});

  function automatic logic [8:0] body_len(input logic [7:0] l);
    logic [9:0] s;
    s = {2'b00, l} + {{2{len_adjust_in[7]}}, len_adjust_in};
    return s[9] ? 9'h000 : s[8:0];
  endfunction

  function automatic fr_pkg::fr_st_e body_st(input logic [8:0] r);
    if (r != 9'h000) begin
      return fr_pkg::ST_BODY;
    end else if (crc_en) begin
      return fr_pkg::ST_CRC;
    end
    return fr_pkg::ST_IDLE;
  endfunction

  function automatic logic [8:0] body_cnt(input logic [8:0] r);
    return (r == 9'h000) ? 9'h001 : r;
  endfunction

  // Where each frame begins
  assign fs_st = fix_en ? body_st({1'b0, fixed_len_in}) : fr_pkg::ST_HEAD;
  assign fs_cnt = fix_en ? body_cnt({1'b0, fixed_len_in}) : {7'h00, len_pos};

  // Register writes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_a_r <= fr_pkg::CTRL_A_RST;
      ctrl_b_r <= fr_pkg::CTRL_B_RST;
      lead_r <= fr_pkg::LEAD_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        fr_pkg::REG_CTRL_A: ctrl_a_r <= reg_wdata_in;
        fr_pkg::REG_CTRL_B: ctrl_b_r <= {1'b0, reg_wdata_in[6:0]};
        fr_pkg::REG_LEAD: lead_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Register reads, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        fr_pkg::REG_CTRL_A: rdata_r <= ctrl_a_r;
        fr_pkg::REG_CTRL_B: rdata_r <= ctrl_b_r;
        fr_pkg::REG_LEAD: rdata_r <= lead_r;
        fr_pkg::REG_STATUS: rdata_r <= {4'h0, rx_result_r, rx_done_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_out = rdata_r;

  // ---------------- Transmit ----------------
  fr_pkg::fr_st_e tx_st_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_bit_r;
  logic [8:0] tx_cnt_r;
  logic tx_have_r, tx_coded_r, tx_lsb_r, tx_iscrc_r, tx_half_r, tx_fstart_r, tx_first_r;
  logic tx_chip_r, tx_vld_r, dir_q_r;
  logic direct, dir_gpio, dir_src;
  logic [3:0] gpio_idx;
  logic tx_free, tx_emit, tx_plain, tx_coded, tx_split, tx_wbit, tx_white_use, tx_bit_done;
  logic tx_need, tx_fifo_src, tx_load, tx_new_coded, tx_new_lsb, tx_new_crc;
  logic [7:0] tx_new;

  assign direct = direct_mod_in > fr_pkg::DM_LAST_FRAMED;
  assign dir_gpio = direct_mod_in >= fr_pkg::DM_GPIO0;
  assign gpio_idx = direct_mod_in - fr_pkg::DM_GPIO0;
  assign dir_src = dir_gpio ? gpio_in[gpio_idx[1:0]] : (direct_mod_in == fr_pkg::DM_FIXED1);

  assign tx_free = !tx_vld_r || tx_chip_ready_in;
  assign tx_emit = (direct || tx_have_r) && tx_free;
  assign tx_plain = direct ? dir_src : (tx_lsb_r ? tx_sh_r[0] : tx_sh_r[7]);
  assign tx_coded = direct || tx_coded_r;
  // Fixed source with both codings on keeps biphase only
  assign tx_white_use = white_en && !(direct && !dir_gpio && bip_en);
  assign tx_wbit = tx_plain ^ (tx_coded && tx_white_use && tx_lane.mask_bit);
  assign tx_split = tx_coded && bip_en;
  assign tx_bit_done = tx_emit && (!tx_split || tx_half_r);

  assign tx_lane.init = (tx_load && tx_fstart_r) || (direct && !dir_q_r);
  assign tx_lane.step = tx_bit_done && tx_coded;
  assign tx_lane.crc_en = !tx_iscrc_r && !direct;
  assign tx_lane.bit_plain = tx_plain;

  assign tx_need = !tx_have_r && !direct && eng_en && (tx_st_r != fr_pkg::ST_IDLE);
  assign tx_load = tx_need && (!tx_fifo_src || tx_byte_valid_in);
  assign tx_byte_ready_out = tx_need && tx_fifo_src;

  // Next byte to shift out
  always_comb begin
    tx_fifo_src = 1'b0;
    tx_new = 8'h00;
    tx_new_coded = 1'b1;
    tx_new_lsb = lsb_en;
    tx_new_crc = 1'b0;
    case (tx_st_r)
      fr_pkg::ST_PRE: begin
        tx_new = lead_r;
        tx_new_coded = 1'b0;
        tx_new_lsb = 1'b1;
      end
      fr_pkg::ST_SYNC: begin
        tx_new = sync_word_in[{tx_cnt_r[1:0], 3'b000} +: 8];
        tx_new_coded = 1'b0;
        tx_new_lsb = 1'b1;
      end
      fr_pkg::ST_BODY: begin
        tx_fifo_src = !(tx_first_r && addr_en);
        tx_new = tx_fifo_src ? tx_byte_in : address_in;
      end
      fr_pkg::ST_CRC: begin
        tx_new = tx_cnt_r[0] ? tx_lane.crc[15:8] : tx_lane.crc[7:0];
        tx_new_crc = 1'b1;
      end
      fr_pkg::ST_HEAD: begin
        tx_fifo_src = 1'b1;
        tx_new = tx_byte_in;
      end
      default: ;
    endcase
  end

  // Transmit sequencer, advances once per loaded byte
  always_ff @(posedge clk_in) begin
    if (reset_in || !eng_en || direct) begin
      tx_st_r <= fr_pkg::ST_IDLE;
      tx_cnt_r <= 9'h000;
      tx_fstart_r <= 1'b0;
      tx_first_r <= 1'b0;
    end else if (tx_st_r == fr_pkg::ST_IDLE) begin
      if (tx_start_in) begin
        tx_fstart_r <= 1'b1;
        tx_first_r <= 1'b1;
        tx_st_r <= pre_en ? fr_pkg::ST_PRE : fs_st;
        tx_cnt_r <= pre_en ? {7'h00, lead_repeat_in} : fs_cnt;
      end
    end else if (tx_load) begin
      tx_fstart_r <= 1'b0;
      case (tx_st_r)
        fr_pkg::ST_PRE: begin
          tx_st_r <= (tx_cnt_r == 9'h000) ? fr_pkg::ST_SYNC : fr_pkg::ST_PRE;
          tx_cnt_r <= (tx_cnt_r == 9'h000) ? 9'h000 : tx_cnt_r - 9'h001;
        end
        fr_pkg::ST_SYNC: begin
          if (tx_cnt_r[1:0] == sync_last) begin
            tx_st_r <= fs_st;
            tx_cnt_r <= fs_cnt;
            tx_fstart_r <= 1'b1;
          end else begin
            tx_cnt_r <= tx_cnt_r + 9'h001;
          end
        end
        fr_pkg::ST_HEAD: begin
          if (tx_cnt_r == 9'h000) begin
            tx_st_r <= body_st(body_len(tx_byte_in));
            tx_cnt_r <= body_cnt(body_len(tx_byte_in));
          end else begin
            tx_cnt_r <= tx_cnt_r - 9'h001;
          end
        end
        fr_pkg::ST_BODY: begin
          tx_first_r <= 1'b0;
          if (tx_cnt_r != 9'h001) begin
            tx_cnt_r <= tx_cnt_r - 9'h001;
          end else if (crc_en) begin
            tx_st_r <= fr_pkg::ST_CRC;
          end else begin
            tx_st_r <= multi_en ? fs_st : fr_pkg::ST_IDLE;
            tx_cnt_r <= fs_cnt;
            tx_fstart_r <= multi_en;
            tx_first_r <= 1'b1;
          end
        end
        fr_pkg::ST_CRC: begin
          if (tx_cnt_r != 9'h000) begin
            tx_cnt_r <= 9'h000;
          end else begin
            tx_st_r <= multi_en ? fs_st : fr_pkg::ST_IDLE;
            tx_cnt_r <= fs_cnt;
            tx_fstart_r <= multi_en;
            tx_first_r <= 1'b1;
          end
        end
        default: tx_st_r <= fr_pkg::ST_IDLE;
      endcase
    end
  end

  // Bit shifter and biphase phase
  always_ff @(posedge clk_in) begin
    if (reset_in || (!eng_en && !direct) || (direct && !dir_q_r)) begin
      tx_have_r <= 1'b0;
      tx_sh_r <= 8'h00;
      tx_bit_r <= 3'h0;
      tx_half_r <= 1'b0;
      tx_coded_r <= 1'b0;
      tx_lsb_r <= 1'b0;
      tx_iscrc_r <= 1'b0;
    end else if (tx_load) begin
      tx_have_r <= 1'b1;
      tx_sh_r <= tx_new;
      tx_bit_r <= 3'h0;
      tx_half_r <= 1'b0;
      tx_coded_r <= tx_new_coded;
      tx_lsb_r <= tx_new_lsb;
      tx_iscrc_r <= tx_new_crc;
    end else if (tx_emit) begin
      if (tx_split && !tx_half_r) begin
        tx_half_r <= 1'b1;
      end else begin
        tx_half_r <= 1'b0;
        if (!direct) begin
          tx_sh_r <= tx_lsb_r ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
          tx_bit_r <= tx_bit_r + 3'h1;
          tx_have_r <= (tx_bit_r != 3'h7);
        end
      end
    end
  end

  // Chip output register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_vld_r <= 1'b0;
      tx_chip_r <= 1'b0;
      dir_q_r <= 1'b0;
    end else begin
      dir_q_r <= direct;
      if (tx_free) begin
        tx_vld_r <= tx_emit;
        if (tx_emit) begin
          tx_chip_r <= tx_split ? (tx_wbit ^ inv_en ^ tx_half_r) : tx_wbit;
        end
      end
    end
  end
  assign tx_chip_out = tx_chip_r;
  assign tx_chip_valid_out = tx_vld_r;
  assign tx_busy_out = (tx_st_r != fr_pkg::ST_IDLE) || tx_have_r || tx_vld_r;

  // ---------------- Receive ----------------
  fr_pkg::fr_st_e rx_st_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_bit_r;
  logic [8:0] rx_cnt_r;
  logic [31:0] rx_hunt_r;
  logic [31:0] rx_hunt_nxt;
  logic [7:0] rx_crc_hi_r;
  logic [7:0] rx_out_r;
  logic rx_out_vld_r, rx_half_r, rx_chip0_r;
  logic rx_coded_st, rx_take, rx_bit_done, rx_w, rx_plain, rx_byte_done, rx_hit, rx_eof, rx_go;
  logic [7:0] rx_nb;

  assign rx_coded_st = (rx_st_r == fr_pkg::ST_HEAD) || (rx_st_r == fr_pkg::ST_BODY) ||
                       (rx_st_r == fr_pkg::ST_CRC);
  assign rx_take = rx_chip_valid_in && rx_coded_st;
  assign rx_bit_done = rx_take && (!bip_en || rx_half_r);
  assign rx_w = bip_en ? (rx_chip0_r ^ inv_en) : rx_chip_in;
  assign rx_plain = rx_w ^ (white_en && rx_lane.mask_bit);
  assign rx_nb = lsb_en ? {rx_plain, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_plain};
  assign rx_byte_done = rx_bit_done && (rx_bit_r == 3'h7);
  assign rx_hunt_nxt = {rx_chip_in, rx_hunt_r[31:1]};
  assign rx_hit = (rx_st_r == fr_pkg::ST_HUNT) && rx_chip_valid_in &&
                  ((rx_hunt_nxt & sync_mask) == (sync_al & sync_mask));
  assign rx_eof = rx_byte_done && (((rx_st_r == fr_pkg::ST_CRC) && (rx_cnt_r == 9'h000)) ||
                  ((rx_st_r == fr_pkg::ST_BODY) && (rx_cnt_r == 9'h001) && !crc_en));
  assign rx_go = rx_hit || (rx_eof && multi_en);

  assign rx_lane.init = rx_go;
  assign rx_lane.step = rx_bit_done;
  assign rx_lane.crc_en = rx_st_r != fr_pkg::ST_CRC;
  assign rx_lane.bit_plain = rx_plain;

  // Receive sequencer, advances once per completed byte
  always_ff @(posedge clk_in) begin
    if (reset_in || !rx_en) begin
      rx_st_r <= fr_pkg::ST_IDLE;
      rx_cnt_r <= 9'h000;
      rx_crc_hi_r <= 8'h00;
    end else if (rx_go) begin
      rx_st_r <= fs_st;
      rx_cnt_r <= fs_cnt;
    end else if (rx_eof) begin
      rx_st_r <= fr_pkg::ST_IDLE;
    end else begin
      case (rx_st_r)
        fr_pkg::ST_IDLE: rx_st_r <= rx_start_in ? fr_pkg::ST_HUNT : fr_pkg::ST_IDLE;
        fr_pkg::ST_HEAD: begin
          if (rx_byte_done && (rx_cnt_r == 9'h000)) begin
            rx_st_r <= body_st(body_len(rx_nb));
            rx_cnt_r <= body_cnt(body_len(rx_nb));
          end else if (rx_byte_done) begin
            rx_cnt_r <= rx_cnt_r - 9'h001;
          end
        end
        fr_pkg::ST_BODY: begin
          if (rx_byte_done && (rx_cnt_r == 9'h001)) begin
            rx_st_r <= fr_pkg::ST_CRC;
          end else if (rx_byte_done) begin
            rx_cnt_r <= rx_cnt_r - 9'h001;
          end
        end
        fr_pkg::ST_CRC: begin
          if (rx_byte_done) begin
            rx_crc_hi_r <= rx_nb;
            rx_cnt_r <= 9'h000;
          end
        end
        default: ;
      endcase
    end
  end

  // Chip pairing, byte assembly and sync hunting
  always_ff @(posedge clk_in) begin
    if (reset_in || rx_go || (rx_st_r == fr_pkg::ST_IDLE)) begin
      rx_half_r <= 1'b0;
      rx_chip0_r <= 1'b0;
      rx_sh_r <= 8'h00;
      rx_bit_r <= 3'h0;
      rx_hunt_r <= 32'h00000000;
    end else begin
      if ((rx_st_r == fr_pkg::ST_HUNT) && rx_chip_valid_in) begin
        rx_hunt_r <= rx_hunt_nxt;
      end
      if (rx_take) begin
        rx_half_r <= bip_en && !rx_half_r;
        rx_chip0_r <= rx_chip_in;
      end
      if (rx_bit_done) begin
        rx_sh_r <= rx_nb;
        rx_bit_r <= rx_bit_r + 3'h1;
      end
    end
  end

  // Received bytes toward the FIFO; checksum bytes stay here
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_out_r <= 8'h00;
      rx_out_vld_r <= 1'b0;
    end else begin
      rx_out_vld_r <= rx_byte_done && (rx_st_r != fr_pkg::ST_CRC);
      if (rx_byte_done) begin
        rx_out_r <= rx_nb;
      end
    end
  end
  assign rx_byte_out = rx_out_r;
  assign rx_byte_valid_out = rx_out_vld_r;

  // Done flag: a new frame end wins over a software clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_done_r <= 1'b0;
      rx_result_r <= fr_pkg::RES_OK;
    end else if (rx_eof) begin
      rx_done_r <= 1'b1;
      rx_result_r <= ((rx_st_r == fr_pkg::ST_CRC) && ({rx_crc_hi_r, rx_nb} != rx_lane.crc)) ?
                     fr_pkg::RES_CRC_ERR : fr_pkg::RES_OK;
    end else if (reg_wr_in && (reg_addr_in == fr_pkg::REG_STATUS) && reg_wdata_in[fr_pkg::ST_DONE]) begin
      rx_done_r <= 1'b0;
    end
  end
  assign rx_done_out = rx_done_r;
  assign rx_result_code_out = rx_result_r;

  fr_lane u_tx_lane (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lp(tx_lane.lane)
  );

  fr_lane u_rx_lane (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lp(rx_lane.lane)
  );
endmodule
`default_nettype wire

// ### verification/fr_asserts.sv
// Port checker for the packet framer.
// Assumes it is bound to fr_framer; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module fr_asserts (
  // Clock, reset, register writes
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Transmit side
  input wire logic [3:0] direct_mod_in,
  input wire logic [3:0] gpio_in,
  input wire logic tx_start_in,
  input wire logic tx_chip_out,
  input wire logic tx_chip_valid_out,
  input wire logic tx_chip_ready_in,
  input wire logic tx_busy_out,
  // Receive side
  input wire logic rx_chip_valid_in,
  input wire logic rx_byte_valid_out,
  input wire logic rx_done_out
);
  logic [7:0] ca_r;
  logic [7:0] cb_r;
  logic plain;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Shadow control bytes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ca_r <= fr_pkg::CTRL_A_RST;
      cb_r <= fr_pkg::CTRL_B_RST;
    end else if (reg_wr_in && reg_addr_in == fr_pkg::REG_CTRL_A) begin
      ca_r <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == fr_pkg::REG_CTRL_B) begin
      cb_r <= reg_wdata_in;
    end
  end
  assign plain = !ca_r[6] && !cb_r[1];
  a_tx_first_chip: assert property (
    tx_start_in && !tx_busy_out && ca_r[0] && direct_mod_in <= 4'h2 |-> ##3 tx_chip_valid_out)
    else $error("no chip after start");
  a_tx_engine_off: assert property (
    tx_start_in && !tx_busy_out && !ca_r[0] |=> !tx_busy_out)
    else $error("start taken with engine off");
  a_rx_enable: assert property (
    rx_byte_valid_out |-> $past(ca_r[0] && cb_r[0]))
    else $error("byte while receive off");
  a_byte_cause: assert property (
    rx_byte_valid_out |-> $past(rx_chip_valid_in))
    else $error("byte without chip");
  a_done_cause: assert property (
    $rose(rx_done_out) |-> $past(rx_chip_valid_in))
    else $error("done without chip");
  a_done_clear: assert property (
    reg_wr_in && reg_addr_in == fr_pkg::REG_STATUS && reg_wdata_in[0] && !rx_chip_valid_in
    && !$past(rx_chip_valid_in) |=> !rx_done_out)
    else $error("done not cleared");
  a_direct_one: assert property (
    (direct_mod_in == fr_pkg::DM_FIXED1 && tx_chip_ready_in && plain) [*6]
    ##0 tx_chip_valid_out |-> tx_chip_out)
    else $error("fixed source chip wrong");
  a_direct_gpio: assert property (
    (direct_mod_in == fr_pkg::DM_GPIO0 && tx_chip_ready_in && plain && $stable(gpio_in)) [*6]
    ##0 tx_chip_valid_out |-> tx_chip_out == gpio_in[0])
    else $error("gpio source chip wrong");
endmodule
bind fr_framer fr_asserts u_chk (.clk_in, .reset_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
  .direct_mod_in, .gpio_in, .tx_start_in, .tx_chip_out, .tx_chip_valid_out, .tx_chip_ready_in,
  .tx_busy_out, .rx_chip_valid_in, .rx_byte_valid_out, .rx_done_out);
`default_nettype wire

// ### verification/fr_radio_model.sv
// Remote radio: takes sent chips and sends them back, optionally one flipped.
// Assumes the framer's clock.
`timescale 1ns/1ps
`default_nettype none
module fr_radio_model (
  // Control
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic restart_in,
  input wire logic [15:0] flip_in,
  // Chips in and out
  input wire logic chip_in,
  input wire logic chip_valid_in,
  output logic chip_ready_out,
  output logic chip_out,
  output logic chip_valid_out
);
  logic q[$];
  logic [15:0] cnt;
  initial begin
    chip_ready_out = 1'b1;
    chip_out = 1'b0;
    chip_valid_out = 1'b0;
    cnt = 16'h0000;
  end
  always @(posedge clk_in) begin
    if (chip_valid_in && chip_ready_out)
      q.push_back(chip_in);
    chip_ready_out <= slow_in ? !chip_ready_out : 1'b1;
    chip_valid_out <= q.size() > 0;
    if (restart_in)
      cnt <= 16'h0000;
    if (q.size() > 0) begin
      chip_out <= q.pop_front() ^ (cnt == flip_in);
      cnt <= cnt + 16'h0001;
    end else begin
      chip_out <= !chip_out;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Bench: frames loop through the radio model back into the framer.
// Assumes design, checker and model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in, reset_in, reg_wr_in, reg_rd_in, tx_start_in, rx_start_in, slow, restart;
  logic tx_byte_valid_in, tx_byte_ready_out, tx_chip_out, tx_chip_valid_out, tx_busy_out;
  logic tx_chip_ready_in, rx_chip_in, rx_chip_valid_in, rx_byte_valid_out, rx_done_out;
  logic [6:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, tx_byte_in, rx_byte_out;
  logic [3:0] direct_mod_in, gpio_in;
  logic [2:0] rx_result_code_out;
  logic [15:0] flip;
  logic [31:0] sw;
  logic [1:0] lrep;
  logic [7:0] txq[$], rxq[$];
  int error_cnt = 0;
  int cmp_count = 0;
  // Length adjust -1, fixed length 3
  fr_framer uut (.clk_in, .reset_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .lead_repeat_in(lrep), .sync_word_in(sw), .fixed_len_in(8'h03),
    .len_adjust_in(8'hff), .address_in(8'h7e), .direct_mod_in, .gpio_in, .tx_start_in,
    .rx_start_in, .tx_byte_in, .tx_byte_valid_in, .tx_byte_ready_out, .tx_chip_out,
    .tx_chip_valid_out, .tx_chip_ready_in, .rx_chip_in, .rx_chip_valid_in, .rx_byte_out,
    .rx_byte_valid_out, .tx_busy_out, .rx_done_out, .rx_result_code_out);
  fr_radio_model radio (.clk_in, .slow_in(slow), .restart_in(restart), .flip_in(flip),
    .chip_in(tx_chip_out), .chip_valid_in(tx_chip_valid_out), .chip_ready_out(tx_chip_ready_in),
    .chip_out(rx_chip_in), .chip_valid_out(rx_chip_valid_in));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = !clk_in;
  end
  // Byte FIFO feed and receive capture
  always @(posedge clk_in) begin
    if (tx_byte_valid_in && tx_byte_ready_out)
      txq.delete(0);
    tx_byte_valid_in <= txq.size() > 0;
    tx_byte_in <= txq.size() > 0 ? txq[0] : ~tx_byte_in;
    if (rx_byte_valid_out)
      rxq.push_back(rx_byte_out);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic pulse(input logic rx);
    @(posedge clk_in);
    restart <= 1'b1;
    rx_start_in <= rx;
    tx_start_in <= 1'b1;
    @(posedge clk_in);
    restart <= 1'b0;
    rx_start_in <= 1'b0;
    tx_start_in <= 1'b0;
    @(negedge clk_in);
  endtask
  // One frame out and back; slot 0 length byte 4 gives three body bytes
  task automatic frame(input logic [7:0] ca, cb, input logic [15:0] fl, input logic sl,
                       input logic [2:0] res);
    logic [7:0] ex[$];
    int n;
    n = 0;
    wr(fr_pkg::REG_CTRL_A, ca);
    wr(fr_pkg::REG_CTRL_B, cb);
    wr(fr_pkg::REG_STATUS, 8'h01);
    rxq = {};
    txq = {8'h04, 8'ha5, 8'h3c};
    if (ca[2])
      txq.delete(0);
    ex = txq;
    ex.insert(ca[2] ? 0 : 1, 8'h7e);
    if (!cb[0])
      ex = {};
    slow <= sl;
    flip <= fl;
    pulse(1'b1);
    while ((tx_busy_out === 1'b1 || rx_chip_valid_in === 1'b1) && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3000) error_cnt++;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk({7'h00, rx_done_out}, {7'h00, cb[0]});
    if (cb[0])
      chk({5'h00, rx_result_code_out}, {5'h00, res});
    chk(8'(rxq.size()), 8'(ex.size()));
    foreach (ex[i]) chk(rxq[i], ex[i]);
  endtask
  task automatic s_regs();
    rdc(fr_pkg::REG_CTRL_A, 8'h00);
    rdc(fr_pkg::REG_CTRL_B, 8'h00);
    rdc(fr_pkg::REG_LEAD, 8'h55);
    rdc(7'h7f, 8'h00);
    pulse(1'b0);
    chk({7'h00, tx_busy_out}, 8'h00);
  endtask
  task automatic s_direct();
    wr(fr_pkg::REG_CTRL_A, 8'h01);
    wr(fr_pkg::REG_CTRL_B, 8'h00);
    direct_mod_in <= fr_pkg::DM_FIXED1;
    repeat (12) @(negedge clk_in);
    chk({6'h00, tx_chip_valid_out, tx_chip_out}, 8'h03);
    @(posedge clk_in);
    direct_mod_in <= fr_pkg::DM_GPIO0;
    repeat (10) @(negedge clk_in);
    chk({6'h00, tx_chip_valid_out, tx_chip_out}, 8'h02);
    @(posedge clk_in);
    gpio_in <= 4'h1;
    repeat (10) @(negedge clk_in);
    chk({6'h00, tx_chip_valid_out, tx_chip_out}, 8'h03);
    @(posedge clk_in);
    direct_mod_in <= 4'h0;
    repeat (4) @(posedge clk_in);
  endtask
  initial begin
    reset_in = 1'b1;
    {reg_wr_in, reg_rd_in, tx_start_in, rx_start_in, slow, restart} = 6'h00;
    {reg_addr_in, reg_wdata_in, tx_byte_in, tx_byte_valid_in} = 24'h000000;
    {lrep, sw, direct_mod_in, gpio_in, flip} = 58'h29e17b3c600ffff;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    s_regs();
    frame(8'h5b, 8'h03, 16'hffff, 1'b0, 3'h0);
    frame(8'hdb, 8'h1f, 16'hffff, 1'b1, 3'h0);
    frame(8'h5b, 8'h03, 16'h0068, 1'b0, fr_pkg::RES_CRC_ERR);
    frame(8'h5f, 8'h03, 16'hffff, 1'b0, 3'h0);
    frame(8'h5b, 8'h02, 16'hffff, 1'b0, 3'h0);
    s_direct();
    close_out();
  end
  initial begin
    repeat (10000) @(posedge clk_in);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
